/* fmic_map.svh */
// offsets, fields and timing figures of the interface control
`ifndef FMIC_MAP_SVH
`define FMIC_MAP_SVH

// =====================================================================
// apb register map
`define FMIC_CTRL_OFF   8'h00
`define FMIC_STAT_OFF   8'h04
`define FMIC_CTRL_HOLD  0
`define FMIC_CTRL_ANS   1
`define FMIC_CTRL_RST   2'h2

// =====================================================================
// time base: one tick every 100 us
`define FMIC_CW         16
`define FMIC_CLK_HZ     10000000
`define FMIC_TICK_US    100
`define FMIC_TICK_CYC   ((`FMIC_CLK_HZ / 1000000) * `FMIC_TICK_US)
// round up to whole ticks
`define FMIC_TK(us)     (16'(((us) + `FMIC_TICK_US - 1) / `FMIC_TICK_US))

// =====================================================================
// times in microseconds
`define FMIC_RC_ON_B103_US   208300
`define FMIC_RC_ON_V21_US    400000
`define FMIC_RC_ON_B202_US   183300
`define FMIC_RC_OFF_US       500
`define FMIC_BRC_ON_US       82300
`define FMIC_BRC_OFF_US      500
`define FMIC_CD_ON_B103_US   94000
`define FMIC_CD_ON_V21_US    301000
`define FMIC_CD_ON_V23_US    11400
`define FMIC_CD_ON_B202_US   18000
`define FMIC_CD_OFF_B103_US  21000
`define FMIC_CD_OFF_V23_US   5400
`define FMIC_CD_OFF_B202_US  12400
`define FMIC_BCD_ON_US       17000
`define FMIC_BCD_OFF_US      5400
`define FMIC_SQL_US          8000
`define FMIC_ANS_US          3000000

`endif

/* fmic_pkg.sv */
// shared types of the modem control
package fmic_pkg;

   // =====================================================================
   // decoded modem family
   typedef enum logic [3:0] {
      FAM_NONE  = 4'h0,
      FAM_B103O = 4'h1,
      FAM_B103A = 4'h2,
      FAM_B202  = 4'h3,
      FAM_V21O  = 4'h4,
      FAM_V21A  = 4'h5,
      FAM_V23M2 = 4'h6,
      FAM_V23M1 = 4'h7,
      FAM_V23BK = 4'h8
   } fmic_fam_t;

   // =====================================================================
   // transmit / auto-answer state machine, one-hot
   typedef enum logic [7:0] {
      S_IDLE  = 8'h01,
      S_RON   = 8'h02,
      S_SEND  = 8'h04,
      S_ROFF  = 8'h08,
      S_BON   = 8'h10,
      S_BSEND = 8'h20,
      S_BOFF  = 8'h40,
      S_ANS   = 8'h80
   } fmic_st_t;

endpackage : fmic_pkg

/* fmic_det_if.sv */
// carrier qualifier hookup
interface fmic_det_if;
   logic                raw;
   logic                tick;
   logic                clr;
   logic [15:0]         on_tk;
   logic [15:0]         off_tk;
   logic                det;
   modport ctl  (output raw, tick, clr, on_tk, off_tk, input det);
   modport qual (input raw, tick, clr, on_tk, off_tk, output det);
endinterface : fmic_det_if

/* fmic_sync.sv */
// two-flop pin synchroniser, resets high
module fmic_sync #(
   parameter int W = 1
)(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;

   // =====================================================================
   // first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= '1;
         s2_ff <= '1;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
      end
   end

   assign q = s2_ff;
endmodule : fmic_sync

/* fmic_qual.sv */
// carrier qualifier: det follows raw after on/off time
`include "fmic_map.svh"
module fmic_qual
   import fmic_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   fmic_det_if.qual  q
);
   logic [`FMIC_CW-1:0] cnt_ff;
   logic                det_ff;
   logic [`FMIC_CW-1:0] lim;

   // off time applies while detected, on time otherwise
   assign lim = det_ff ? q.off_tk : q.on_tk;

   // =====================================================================
   // a glitch restarts the count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= '0;
         det_ff <= 1'b0;
      end else if (q.clr) begin
         cnt_ff <= '0;
         det_ff <= 1'b0;
      end else if (q.raw == det_ff) begin
         cnt_ff <= '0;
      end else if (q.tick) begin
         if (cnt_ff + 16'h1 >= lim) begin
            cnt_ff <= '0;
            det_ff <= q.raw;
         end else begin
            cnt_ff <= cnt_ff + 16'h1;
         end
      end
   end

   assign q.det = det_ff;
endmodule : fmic_qual

/* fmic_top.sv */
// modem interface control top
`include "fmic_map.svh"
// =====================================================================
// Notes on behaviour
// - five select bits, nineteen usable
// - codes 0-8 normal modes
// - codes 16-25 loopback, one filter band
// - ready high disables all
// - request low transmits, high stops
// - clear follows request after delays
// - on delay 208.3/400/183.3 ms
// - off delay 0.5 ms
// - carrier detect on/off qualified
// - carrier needs both enables low
// - received data clamped to mark
// - back request only half-duplex
// - back data picks back frequency
// - 202 back tone keyed by back data
// - back clear only in V.23
// - back detect on back carrier
// - back data clamped high when invalid
// - ring while ready answers
// - async active-low reset
// - ready drop restores initial state
module fmic_top
   import fmic_pkg::*;
#(
   parameter int                  TICK_CYC = `FMIC_TICK_CYC,
   parameter logic [`FMIC_CW-1:0] ANS_TK   = `FMIC_TK(`FMIC_ANS_US)
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [4:0]  config_select,
   input  wire logic        dtr_n,
   input  wire logic        rts_n,
   input  wire logic        tx_serial,
   input  wire logic        back_send_request_n,
   input  wire logic        back_tx_serial,
   input  wire logic        ring_n,
   input  wire logic        carrier_in_main,
   input  wire logic        carrier_in_back,
   input  wire logic        rx_bit,
   input  wire logic        back_rx_bit,
   output logic             cts_n,
   output logic             cd_n,
   output logic             rx_serial,
   output logic             back_send_clear_n,
   output logic             back_cd_n,
   output logic             back_rx_serial,
   output logic             carrier_out_en,
   output logic             carrier_out_mark,
   output logic             carrier_out_back,
   output logic             answer_tone,
   output fmic_fam_t        mode_family,
   output logic             compromise_eq,
   output logic             common_band
);
   localparam int CW = `FMIC_CW;

   // =====================================================================
   // pin synchronisers
   logic [4:0]  cfg_s;
   logic        dtr_s;
   logic        rts_s;
   logic        td_s;
   logic        back_send_request_n_s;
   logic        btd_s;
   logic        ring_s;

   fmic_sync #(.W(11)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({config_select, dtr_n, rts_n, tx_serial,
                 back_send_request_n, back_tx_serial, ring_n}),
      .q       ({cfg_s, dtr_s, rts_s, td_s, back_send_request_n_s, btd_s, ring_s})
   );

   // =====================================================================
   // tick divider: 100 us enables
   logic [15:0] div_ff;
   logic        tick_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff  <= '0;
         tick_ff <= 1'b0;
      end else if (div_ff == 16'(TICK_CYC - 1)) begin
         div_ff  <= '0;
         tick_ff <= 1'b1;
      end else begin
         div_ff  <= div_ff + 16'h1;
         tick_ff <= 1'b0;
      end
   end

   // =====================================================================
   // configuration decode
   function automatic fmic_fam_t dec_fam(input logic [4:0] c);
      fmic_fam_t f;
      f = FAM_NONE;
      unique case (c)
         5'h00, 5'h10:               f = FAM_B103O;
         5'h01, 5'h11:               f = FAM_B103A;
         5'h02, 5'h03, 5'h12, 5'h13: f = FAM_B202;
         5'h04, 5'h14:               f = FAM_V21O;
         5'h05, 5'h15:               f = FAM_V21A;
         5'h06, 5'h07, 5'h16, 5'h17: f = FAM_V23M2;
         5'h08, 5'h18:               f = FAM_V23M1;
         5'h19:                      f = FAM_V23BK;
         default:                    f = FAM_NONE;
      endcase
      return f;
   endfunction : dec_fam

   fmic_fam_t fam_ff;
   logic      eq_ff;
   logic      lb_ff;

   // reserved codes leave the block idle rather than half-configured
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fam_ff <= FAM_NONE;
         eq_ff  <= 1'b0;
         lb_ff  <= 1'b0;
      end else begin
         fam_ff <= dec_fam(cfg_s);
         eq_ff  <= (cfg_s[3:0] == 4'h3) || (cfg_s[3:0] == 4'h7);
         lb_ff  <= cfg_s[4] && (dec_fam(cfg_s) != FAM_NONE);
      end
   end

   logic half;
   logic v23;
   logic b202;

   assign v23  = (fam_ff == FAM_V23M2) || (fam_ff == FAM_V23M1) || (fam_ff == FAM_V23BK);
   assign b202 = (fam_ff == FAM_B202);
   assign half = v23 || b202;

   // =====================================================================
   // apb control register, block gating
   logic [1:0] ctrl_ff;
   logic       active;
   logic       acc;
   logic       pready_ff;

   assign acc    = psel && penable;
   assign active = !dtr_s && !ctrl_ff[`FMIC_CTRL_HOLD] && (fam_ff != FAM_NONE);

   // write lands when pready is seen high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= `FMIC_CTRL_RST;
      end else if (acc && pready_ff && pwrite && (paddr == `FMIC_CTRL_OFF)) begin
         ctrl_ff <= pwdata[1:0];
      end
   end

   // =====================================================================
   // per-family delays
   logic [CW-1:0] rc_on;
   logic [CW-1:0] cd_on;
   logic [CW-1:0] cd_off;

   always_comb begin
      rc_on  = `FMIC_TK(`FMIC_RC_ON_B103_US);
      cd_on  = `FMIC_TK(`FMIC_CD_ON_B103_US);
      cd_off = `FMIC_TK(`FMIC_CD_OFF_B103_US);
      unique case (fam_ff)
         FAM_V21O, FAM_V21A: begin
            rc_on = `FMIC_TK(`FMIC_RC_ON_V21_US);
            cd_on = `FMIC_TK(`FMIC_CD_ON_V21_US);
         end
         FAM_B202: begin
            rc_on  = `FMIC_TK(`FMIC_RC_ON_B202_US);
            cd_on  = `FMIC_TK(`FMIC_CD_ON_B202_US);
            cd_off = `FMIC_TK(`FMIC_CD_OFF_B202_US);
         end
         FAM_V23M2, FAM_V23M1, FAM_V23BK: begin
            cd_on  = `FMIC_TK(`FMIC_CD_ON_V23_US);
            cd_off = `FMIC_TK(`FMIC_CD_OFF_V23_US);
         end
         default: begin
         end
      endcase
   end

   // =====================================================================
   // transmit and auto-answer state machine
   fmic_st_t      st_ff;
   logic [CW-1:0] tmr_ff;
   logic          tdone;

   assign tdone = (tmr_ff == '0);

   // main request wins if both are raised
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff  <= S_IDLE;
         tmr_ff <= '0;
      end else if (!active) begin
         st_ff  <= S_IDLE;
         tmr_ff <= '0;
      end else begin
         if (tick_ff && !tdone) begin
            tmr_ff <= tmr_ff - 16'h1;
         end
         unique case (st_ff)
            S_IDLE: begin
               if (!ring_s && ctrl_ff[`FMIC_CTRL_ANS]) begin
                  st_ff  <= S_ANS;
                  tmr_ff <= ANS_TK;
               end else if (!rts_s) begin
                  st_ff  <= S_RON;
                  tmr_ff <= rc_on;
               end else if (!back_send_request_n_s && half) begin
                  st_ff  <= S_BON;
                  tmr_ff <= v23 ? `FMIC_TK(`FMIC_BRC_ON_US) : '0;
               end
            end
            S_RON: begin
               if (rts_s) begin
                  st_ff <= S_IDLE;
               end else if (tdone) begin
                  st_ff <= S_SEND;
               end
            end
            S_SEND: begin
               if (rts_s) begin
                  st_ff  <= S_ROFF;
                  tmr_ff <= `FMIC_TK(`FMIC_RC_OFF_US);
               end
            end
            S_ROFF: begin
               if (tdone) begin
                  st_ff <= S_IDLE;
               end
            end
            S_BON: begin
               if (back_send_request_n_s) begin
                  st_ff <= S_IDLE;
               end else if (tdone) begin
                  st_ff <= S_BSEND;
               end
            end
            S_BSEND: begin
               if (back_send_request_n_s) begin
                  st_ff  <= S_BOFF;
                  tmr_ff <= `FMIC_TK(`FMIC_BRC_OFF_US);
               end
            end
            S_BOFF: begin
               if (tdone) begin
                  st_ff <= S_IDLE;
               end
            end
            S_ANS: begin
               if (tdone) begin
                  st_ff <= S_IDLE;
               end
            end
            default: begin
               st_ff <= S_IDLE;
            end
         endcase
      end
   end

   // =====================================================================
   // receive squelch after a half-duplex turnaround
   logic [CW-1:0] sql_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sql_ff <= '0;
      end else if (!active) begin
         sql_ff <= '0;
      end else if (half && tdone && ((st_ff == S_ROFF) || (st_ff == S_BOFF))) begin
         sql_ff <= `FMIC_TK(`FMIC_SQL_US);
      end else if (tick_ff && (sql_ff != '0)) begin
         sql_ff <= sql_ff - 16'h1;
      end
   end

   // =====================================================================
   // carrier qualifiers
   fmic_det_if cd_if ();
   fmic_det_if bcd_if ();

   assign cd_if.raw     = carrier_in_main;
   assign cd_if.tick    = tick_ff;
   assign cd_if.clr     = !active;
   assign cd_if.on_tk   = cd_on;
   assign cd_if.off_tk  = cd_off;
   assign bcd_if.raw    = carrier_in_back && half;
   assign bcd_if.tick   = tick_ff;
   assign bcd_if.clr    = !active;
   assign bcd_if.on_tk  = `FMIC_TK(`FMIC_BCD_ON_US);
   assign bcd_if.off_tk = `FMIC_TK(`FMIC_BCD_OFF_US);

   fmic_qual u_cd (
      .pclk    (pclk),
      .presetn (presetn),
      .q       (cd_if.qual)
   );

   fmic_qual u_bcd (
      .pclk    (pclk),
      .presetn (presetn),
      .q       (bcd_if.qual)
   );

   // =====================================================================
   // handshake outputs
   logic cts_n_ff;
   logic bclr_n_ff;
   logic cd_n_ff;
   logic bcd_n_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cts_n_ff  <= 1'b1;
         bclr_n_ff <= 1'b1;
         cd_n_ff   <= 1'b1;
         bcd_n_ff  <= 1'b1;
      end else begin
         cts_n_ff  <= !(active && ((st_ff == S_SEND) || (st_ff == S_ROFF)));
         bclr_n_ff <= !(active && v23 && ((st_ff == S_BSEND) || (st_ff == S_BOFF)));
         cd_n_ff   <= !(active && cd_if.det);
         bcd_n_ff  <= !(active && bcd_if.det);
      end
   end

   // =====================================================================
   // modulator control
   logic ans;
   logic main_on;
   logic back_on;
   logic tx_en_ff;
   logic tx_mark_ff;
   logic tx_back_ff;
   logic ans_ff;

   assign ans     = active && (st_ff == S_ANS);
   assign main_on = active && !rts_s && ((st_ff == S_RON) || (st_ff == S_SEND));
   // 202 back is on/off keyed: tone only on mark
   assign back_on = active && !back_send_request_n_s && ((st_ff == S_BON) || (st_ff == S_BSEND))
                    && (v23 || (b202 && btd_s));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_en_ff   <= 1'b0;
         tx_mark_ff <= 1'b1;
         tx_back_ff <= 1'b0;
         ans_ff     <= 1'b0;
      end else begin
         tx_en_ff   <= main_on || back_on || ans;
         tx_mark_ff <= ans || (back_on ? btd_s : td_s);
         tx_back_ff <= back_on;
         ans_ff     <= ans;
      end
   end

   // =====================================================================
   // receive data clamps to mark
   logic rd_force;
   logic brd_force;
   logic rd_ff;
   logic brd_ff;

   assign rd_force  = !active || !cd_if.det || (sql_ff != '0) || ans
                      || (b202 && (st_ff == S_ROFF))
                      || (half && !rts_s && back_send_request_n_s);
   assign brd_force = !active || !v23 || ans || !bcd_if.det
                      || (!back_send_request_n_s && rts_s);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ff  <= 1'b1;
         brd_ff <= 1'b1;
      end else begin
         rd_ff  <= rd_force || rx_bit;
         brd_ff <= brd_force || back_rx_bit;
      end
   end

   // =====================================================================
   // apb read: one wait state, error if unmapped
   logic [31:0] prdata_ff;
   logic        pslverr_ff;
   logic [31:0] stat;
   logic        hit;

   assign hit  = (paddr == `FMIC_CTRL_OFF) || (paddr == `FMIC_STAT_OFF);
   assign stat = {12'h0, fam_ff, st_ff, lb_ff, eq_ff, active, (sql_ff != '0),
                  !cts_n_ff, !cd_n_ff, !bclr_n_ff, !bcd_n_ff};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= '0;
      end else begin
         pready_ff <= acc && !pready_ff;
         if (acc && !pready_ff) begin
            pslverr_ff <= !hit;
            prdata_ff  <= (pwrite || !hit) ? 32'h0 :
                          (paddr == `FMIC_CTRL_OFF) ? {30'h0, ctrl_ff} : stat;
         end
      end
   end

   // =====================================================================
   // outputs straight from flops
   assign prdata            = prdata_ff;
   assign pready            = pready_ff;
   assign pslverr           = pslverr_ff;
   assign cts_n             = cts_n_ff;
   assign cd_n              = cd_n_ff;
   assign rx_serial         = rd_ff;
   assign back_send_clear_n = bclr_n_ff;
   assign back_cd_n         = bcd_n_ff;
   assign back_rx_serial    = brd_ff;
   assign carrier_out_en    = tx_en_ff;
   assign carrier_out_mark  = tx_mark_ff;
   assign carrier_out_back  = tx_back_ff;
   assign answer_tone       = ans_ff;
   assign mode_family       = fam_ff;
   assign compromise_eq     = eq_ff;
   assign common_band       = lb_ff;
endmodule : fmic_top

/* fmic_assertions.sv */
// port assertions bound onto the modem control top
module fmic_assertions
   import fmic_pkg::*;
#(
   parameter int TICK_CYC = 1000
)(
   input wire logic      pclk,
   input wire logic      presetn,
   input wire logic      dtr_n,
   input wire logic      rts_n,
   input wire logic      back_send_request_n,
   input wire logic      cts_n,
   input wire logic      cd_n,
   input wire logic      rx_serial,
   input wire logic      back_send_clear_n,
   input wire logic      back_rx_serial,
   input wire logic      carrier_out_en,
   input wire logic      answer_tone,
   input wire fmic_fam_t mode_family
);
   // =====================================================================
   // counters: delays exceed any repetition bound
   logic [31:0] on_ff;
   logic [31:0] off_ff;
   logic        fdx;
   assign fdx = mode_family inside {FAM_B103O, FAM_B103A, FAM_V21O, FAM_V21A};
   // cycles of request on
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) on_ff <= '0;
      else on_ff <= (!rts_n && !dtr_n) ? on_ff + 32'h1 : '0;
   // clear still on after request off
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) off_ff <= '0;
      else off_ff <= (rts_n && !cts_n && !dtr_n) ? off_ff + 32'h1 : '0;

   // =====================================================================
   // properties
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_cts_dtr; dtr_n [*6] |-> cts_n && back_send_clear_n && !carrier_out_en; endproperty
   a_cts_dtr: assert property (p_cts_dtr) else $error("handshake on while terminal off");
   property p_init_dtr; dtr_n [*6] |-> cd_n && rx_serial && back_rx_serial; endproperty
   a_init_dtr: assert property (p_init_dtr) else $error("outputs not at idle");
   property p_tx_gate; (rts_n && back_send_request_n) [*6] |-> !carrier_out_en || answer_tone;
   endproperty
   a_tx_gate: assert property (p_tx_gate) else $error("carrier without request");
   // one tick of slack for the first tick
   property p_cts_on; $fell(cts_n) |-> on_ff >= 1832 * TICK_CYC; endproperty
   a_cts_on: assert property (p_cts_on) else $error("clear came too early");
   property p_cts_hold; $rose(rts_n) && !cts_n && !dtr_n |-> !cts_n [*8]; endproperty
   a_cts_hold: assert property (p_cts_hold) else $error("clear dropped too early");
   property p_cts_off; off_ff <= 5 * TICK_CYC + 8; endproperty
   a_cts_off: assert property (p_cts_off) else $error("clear held too long");
   property p_rx_clamp; cd_n [*3] |-> rx_serial; endproperty
   a_rx_clamp: assert property (p_rx_clamp) else $error("data not at mark");
   property p_back_ign; fdx [*4] |-> back_rx_serial && back_send_clear_n; endproperty
   a_back_ign: assert property (p_back_ign) else $error("back channel live");
   property p_back_send_clear_n_v23; !back_send_clear_n |-> mode_family inside {FAM_V23M2, FAM_V23M1, FAM_V23BK};
   endproperty
   a_back_send_clear_n_v23: assert property (p_back_send_clear_n_v23) else $error("back clear outside v23");
   property p_ans; answer_tone && $past(answer_tone) |-> carrier_out_en && rx_serial; endproperty
   a_ans: assert property (p_ans) else $error("answer tone without carrier");
endmodule : fmic_assertions

bind fmic_top fmic_assertions #(.TICK_CYC(TICK_CYC)) chk_u (.*);

/* fmic_term.sv */
// terminal model for the handshake inputs
module fmic_term (
   input  wire logic pclk,
   input  wire logic want_main,
   input  wire logic want_back,
   input  wire logic cts_n,
   output logic      rts_n = 1'b1,
   output logic      back_send_request_n = 1'b1,
   output logic      tx_serial = 1'b1,
   output logic      back_tx_serial = 1'b1
);
   timeunit 1ns;
   timeprecision 1ns;
   // =====================================================================
   // levels move just after an edge
   always @(posedge pclk) begin
      rts_n <= !want_main;
      back_send_request_n <= !(want_back && !want_main);
      tx_serial <= cts_n;
      back_tx_serial <= 1'b1;
   end
endmodule : fmic_term

/* tb_top.sv */
// self-checking bench for the modem control
module tb_top
   import fmic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // =====================================================================
   // short ticks keep the run brief
   localparam int        TK = 2;
   localparam fmic_fam_t FAM_TAB [10] = '{FAM_B103O, FAM_B103A, FAM_B202, FAM_B202, FAM_V21O,
                                          FAM_V21A, FAM_V23M2, FAM_V23M2, FAM_V23M1, FAM_V23BK};
   localparam int        ON_CODE [4] = '{0, 2, 4, 6};
   localparam int        ON_TK [4] = '{2083, 1833, 4000, 2083};
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [4:0]  config_select = 5'h00;
   logic        dtr_n = 1'b1, ring_n = 1'b1, carrier_in_main = 1'b0, rx_bit = 1'b1, er;
   logic        want_main = 1'b0, want_back = 1'b0, pready, pslverr, rts_n, back_send_request_n;
   logic        tx_serial, back_tx_serial, cts_n, cd_n, rx_serial, back_send_clear_n, back_cd_n;
   logic        back_rx_serial, carrier_out_en, carrier_out_mark, carrier_out_back, answer_tone;
   logic        compromise_eq, common_band;
   fmic_fam_t   mode_family;
   int          n, miscompares = 0, tests_run = 0;
   fmic_term term_u (.*);
   fmic_top #(.TICK_CYC(TK), .ANS_TK(16'h0005)) dut_u (.*, .carrier_in_back(carrier_in_main),
                                                      .back_rx_bit(1'b1));
   initial begin
      forever #50 pclk = ~pclk;
   end
   // =====================================================================
   // checks, bus and waits
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rng(input int lo, input int hi);
      chk(32'(n >= lo && n <= hi), 32'h1);
   endtask : rng
   // held from setup until pready seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   function automatic logic sig(input int s);
      case (s)
         0: return cts_n;
         1: return cd_n;
         2: return back_send_clear_n;
         default: return answer_tone;
      endcase
   endfunction : sig
   // n: edges spent, or lim on run-out
   task automatic wait_for(input int s, input logic v, input int lim);
      n = 0;
      while (sig(s) !== v && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask : wait_for
   task automatic test_done;
      if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // =====================================================================
   // main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, 8'h04, 32'hff);
      apb(1'b0, 8'h08, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h2);
      dtr_n <= 1'b0;
      for (int c = 0; c < 26; c++) begin
         if (c < 9 || c > 15) begin
            config_select <= 5'(c);
            repeat (8) @(posedge pclk);
            chk(mode_family, FAM_TAB[c % 16]);
            chk(compromise_eq, c % 16 == 3 || c % 16 == 7);
            chk(common_band, c > 15);
         end
      end
      // main handshake per delay family
      for (int i = 0; i < 4; i++) begin
         config_select <= 5'(ON_CODE[i]);
         repeat (8) @(posedge pclk);
         want_main <= 1'b1;
         wait_for(0, 1'b0, 20000);
         rng(ON_TK[i] * TK - 2, ON_TK[i] * TK + 12);
         chk(carrier_out_en, 1'b1);
         repeat (6) @(posedge pclk);
         chk(carrier_out_mark, 1'b0);
         want_main <= 1'b0;
         wait_for(0, 1'b1, 100);
         rng(8, 20);
         chk(carrier_out_en, 1'b0);
         repeat (300) @(posedge pclk);
      end
      // request dropped in on delay: no clear
      config_select <= 5'h00;
      want_main <= 1'b1;
      repeat (100) @(posedge pclk);
      want_main <= 1'b0;
      wait_for(0, 1'b0, 5000);
      chk(32'(n), 32'd5000);
      // back channel: v23, then ignored
      config_select <= 5'h06;
      want_back <= 1'b1;
      wait_for(2, 1'b0, 4000);
      rng(1640, 1660);
      chk(carrier_out_back, 1'b1);
      want_back <= 1'b0;
      wait_for(2, 1'b1, 100);
      rng(1, 20);
      config_select <= 5'h00;
      repeat (300) @(posedge pclk);
      want_back <= 1'b1;
      wait_for(2, 1'b0, 2000);
      chk(32'(n), 32'd2000);
      chk(carrier_out_en, 1'b0);
      want_back <= 1'b0;
      // carrier detect times, data clamp
      config_select <= 5'h02;
      repeat (300) @(posedge pclk);
      carrier_in_main <= 1'b1;
      rx_bit <= 1'b0;
      wait_for(1, 1'b0, 1000);
      rng(358, 372);
      chk(back_cd_n, 1'b0);
      repeat (4) @(posedge pclk);
      chk(rx_serial, 1'b0);
      carrier_in_main <= 1'b0;
      wait_for(1, 1'b1, 1000);
      rng(246, 260);
      chk(back_cd_n, 1'b1);
      repeat (4) @(posedge pclk);
      chk(rx_serial, 1'b1);
      // ring, then terminal drop mid-send
      config_select <= 5'h01;
      ring_n <= 1'b0;
      wait_for(3, 1'b1, 20);
      rng(1, 19);
      ring_n <= 1'b1;
      chk(rx_serial, 1'b1);
      wait_for(3, 1'b0, 40);
      rng(7, 14);
      repeat (300) @(posedge pclk);
      want_main <= 1'b1;
      wait_for(0, 1'b0, 5000);
      dtr_n <= 1'b1;
      wait_for(0, 1'b1, 250);
      rng(1, 249);
      want_main <= 1'b0;
      test_done();
   end
   // watchdog past the ~36000-cycle run
   initial begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      test_done();
   end
endmodule : tb_top
